// >>> core/pswc_ctrl.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "pswc_regs.svh"

// What this block does
// - Deviation inside band longer than detect time: decelerate to stop, enter constant pressure.
// - Deviation level accepts 0 to 100 percent of setpoint, defaults to zero.
// - Detection time accepts 1 to 9999 seconds, defaults to 10.
// - Stop deceleration uses the drive's stop deceleration time, not its own rate.
// - During deceleration, ready while deviation stays within the band.
// - Feedback below setpoint minus the larger of allowed deviation and leakage offset: leave stop and run again.
// - In constant pressure, restart when leakage exceeds both offset level times setpoint and the deviation band.
// - Leakage change threshold accepts 0 to 100 percent; zero disables; default zero.
// - Leakage window accepts 0.1 to 10.0 seconds; zero disables; default 0.5.
// - Flag leakage when feedback change within window is below the threshold.
// - In constant pressure, resume when feedback falls by at least the threshold over the window.
module pswc_ctrl
	import pswc_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = `PSWC_SEC_CYCLES,
	parameter int unsigned WIN_CYCLES = `PSWC_WIN_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic [11:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire pswc_pid_t pid_i,
	input wire logic motor_stopped_i,
	output logic run_req_o,
	output logic stop_decel_req_o,
	output pswc_status_t status_o
);

	logic [15:0] setpoint_deviation_level;
	logic [15:0] deviation_detect_time;
	logic [15:0] leakage_offset_level;
	logic [15:0] leakage_change_threshold;
	logic [15:0] leakage_change_window;

	pswc_state_t state;
	pswc_state_t next_state;

	logic [15:0] dev_band;
	logic [15:0] off_band;
	logic [15:0] thr_band;
	logic [15:0] err;
	logic [15:0] drop;
	logic in_band;
	logic leak_trip;
	logic sec_tick;
	logic win_tick;
	logic [15:0] sec_cnt;
	logic [15:0] win_cnt;
	logic [15:0] win_sample;
	logic win_valid;
	logic leak_flag;
	logic fast_drop;
	logic chg_en;
	logic win_end;
	logic [15:0] win_change;
	logic [15:0] win_fall;

	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		if (v > hi) begin
			return hi;
		end else if (v < lo) begin
			return lo;
		end
		return v;
	endfunction

	function automatic logic [15:0] pct_of(input logic [15:0] sp, input logic [15:0] pct);
		logic [31:0] prod;
		prod = 32'(sp) * 32'(pct);
		return 16'(prod / `PSWC_PERCENT_DIV);
	endfunction

	// Register writes, clamped into the accepted ranges
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			setpoint_deviation_level <= `PSWC_RST_DEV_LEVEL;
			deviation_detect_time <= `PSWC_RST_DETECT_TIME;
			leakage_offset_level <= `PSWC_RST_LEAK_OFFSET;
			leakage_change_threshold <= `PSWC_RST_LEAK_THRESH;
			leakage_change_window <= `PSWC_RST_LEAK_WINDOW;
		end else if (wr_i) begin
			if (addr_i == `PSWC_OFS_DEV_LEVEL) begin
				setpoint_deviation_level <= clamp(wdata_i, 16'h0000,
					`PSWC_MAX_DEV_LEVEL);
			end else if (addr_i == `PSWC_OFS_DETECT_TIME) begin
				deviation_detect_time <= clamp(wdata_i, `PSWC_MIN_DETECT_TIME,
					`PSWC_MAX_DETECT_TIME);
			end else if (addr_i == `PSWC_OFS_LEAK_OFFSET) begin
				leakage_offset_level <= clamp(wdata_i, 16'h0000,
					`PSWC_MAX_LEAK_OFFSET);
			end else if (addr_i == `PSWC_OFS_LEAK_THRESH) begin
				leakage_change_threshold <= clamp(wdata_i, 16'h0000,
					`PSWC_MAX_LEAK_THRESH);
			end else if (addr_i == `PSWC_OFS_LEAK_WINDOW) begin
				leakage_change_window <= clamp(wdata_i, 16'h0000,
					`PSWC_MAX_LEAK_WINDOW);
			end
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			if (addr_i == `PSWC_OFS_DEV_LEVEL) begin
				rdata_o <= setpoint_deviation_level;
			end else if (addr_i == `PSWC_OFS_DETECT_TIME) begin
				rdata_o <= deviation_detect_time;
			end else if (addr_i == `PSWC_OFS_LEAK_OFFSET) begin
				rdata_o <= leakage_offset_level;
			end else if (addr_i == `PSWC_OFS_LEAK_THRESH) begin
				rdata_o <= leakage_change_threshold;
			end else if (addr_i == `PSWC_OFS_LEAK_WINDOW) begin
				rdata_o <= leakage_change_window;
			end else if (addr_i == `PSWC_OFS_STATUS) begin
				rdata_o <= {11'h000, status_o};
			end else begin
				rdata_o <= 16'h0000;
			end
		end else begin
			rdata_o <= 16'h0000;
		end
	end

	// Bands in feedback units, registered to break the multiply path
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dev_band <= 16'h0000;
			off_band <= 16'h0000;
			thr_band <= 16'h0000;
		end else begin
			dev_band <= pct_of(pid_i.setpoint, setpoint_deviation_level);
			off_band <= pct_of(pid_i.setpoint, leakage_offset_level);
			thr_band <= pct_of(pid_i.setpoint, leakage_change_threshold);
		end
	end

	assign err = (pid_i.feedback > pid_i.setpoint) ? pid_i.feedback - pid_i.setpoint
		: pid_i.setpoint - pid_i.feedback;
	assign drop = (pid_i.setpoint > pid_i.feedback) ? pid_i.setpoint - pid_i.feedback
		: 16'h0000;
	assign in_band = err < dev_band;
	// Pressure lost beyond both the deviation band and the leakage offset
	assign leak_trip = (drop > dev_band) && (drop > off_band);

	// Seconds timebase, held cleared outside the band
	pswc_tick #(
		.PERIOD(SEC_CYCLES)
	) u_sec_tick (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.clr_i(!in_band || state != PSWC_RUN),
		.tick_o(sec_tick)
	);

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sec_cnt <= 16'h0000;
		end else if (!in_band || state != PSWC_RUN) begin
			sec_cnt <= 16'h0000;
		end else if (sec_tick && sec_cnt != 16'hffff) begin
			sec_cnt <= sec_cnt + 16'h0001;
		end
	end

	// Leakage change detection over the window
	assign chg_en = (leakage_change_threshold != 16'h0000)
		&& (leakage_change_window != 16'h0000);

	pswc_tick #(
		.PERIOD(WIN_CYCLES)
	) u_win_tick (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.clr_i(!chg_en),
		.tick_o(win_tick)
	);

	assign win_end = win_tick && (win_cnt + 16'h0001 >= leakage_change_window);
	assign win_change = (win_sample > pid_i.feedback) ? win_sample - pid_i.feedback
		: pid_i.feedback - win_sample;
	assign win_fall = (win_sample > pid_i.feedback) ? win_sample - pid_i.feedback : 16'h0000;

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			win_cnt <= 16'h0000;
		end else if (!chg_en || win_end) begin
			win_cnt <= 16'h0000;
		end else if (win_tick) begin
			win_cnt <= win_cnt + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			win_sample <= 16'h0000;
			win_valid <= 1'b0;
		end else if (!chg_en) begin
			win_valid <= 1'b0;
		end else if (win_end) begin
			win_sample <= pid_i.feedback;
			win_valid <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			leak_flag <= 1'b0;
			fast_drop <= 1'b0;
		end else if (!chg_en) begin
			leak_flag <= 1'b0;
			fast_drop <= 1'b0;
		end else if (win_end && win_valid) begin
			leak_flag <= win_change < thr_band;
			fast_drop <= (state == PSWC_CP) && (win_fall >= thr_band);
		end else begin
			fast_drop <= 1'b0;
		end
	end

	// Sleep and wake sequencing
	always_comb begin
		next_state = state;
		case (state)
			PSWC_RUN: begin
				if (in_band && sec_cnt >= deviation_detect_time) begin
					next_state = PSWC_DECEL;
				end
			end
			PSWC_DECEL: begin
				if (!in_band && leak_trip) begin
					next_state = PSWC_RUN;
				end else if (motor_stopped_i) begin
					next_state = PSWC_CP;
				end
			end
			PSWC_CP: begin
				if (leak_trip || fast_drop) begin
					next_state = PSWC_RUN;
				end
			end
			default: begin
				next_state = PSWC_RUN;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= PSWC_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Decel request only; the speed unit ramps with its stop deceleration time
	assign stop_decel_req_o = (state == PSWC_DECEL);
	assign run_req_o = (state == PSWC_RUN);

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			status_o <= '0;
		end else begin
			status_o.run <= (next_state == PSWC_RUN);
			status_o.decel <= (next_state == PSWC_DECEL);
			status_o.cp <= (next_state == PSWC_CP);
			status_o.ready <= (next_state == PSWC_DECEL) && in_band;
			status_o.leak <= leak_flag;
		end
	end

endmodule // pswc_ctrl

// >>> core/pswc_regs.svh
`ifndef PSWC_REGS_SVH
`define PSWC_REGS_SVH

// Register offsets
`define PSWC_OFS_DEV_LEVEL 12'hc00
`define PSWC_OFS_DETECT_TIME 12'hc01
`define PSWC_OFS_LEAK_OFFSET 12'hc02
`define PSWC_OFS_LEAK_THRESH 12'hc03
`define PSWC_OFS_LEAK_WINDOW 12'hc04
`define PSWC_OFS_STATUS 12'hc10

// Reset values
`define PSWC_RST_DEV_LEVEL 16'h0000
`define PSWC_RST_DETECT_TIME 16'h000a
`define PSWC_RST_LEAK_OFFSET 16'h0000
`define PSWC_RST_LEAK_THRESH 16'h0000
`define PSWC_RST_LEAK_WINDOW 16'h0005

// Accepted ranges
`define PSWC_MAX_DEV_LEVEL 16'h0064
`define PSWC_MIN_DETECT_TIME 16'h0001
`define PSWC_MAX_DETECT_TIME 16'h270f
`define PSWC_MAX_LEAK_OFFSET 16'h0032
`define PSWC_MAX_LEAK_THRESH 16'h0064
`define PSWC_MAX_LEAK_WINDOW 16'h0064
`define PSWC_PERCENT_DIV 32'h0000_0064

// Status field positions
`define PSWC_STAT_RUN 0
`define PSWC_STAT_DECEL 1
`define PSWC_STAT_CP 2
`define PSWC_STAT_READY 3
`define PSWC_STAT_LEAK 4

// Timing
`define PSWC_CLK_HZ 40000000
`define PSWC_DETECT_UNIT_S 1
`define PSWC_WINDOW_UNIT_MS 100
`define PSWC_SEC_CYCLES (`PSWC_CLK_HZ * `PSWC_DETECT_UNIT_S)
`define PSWC_WIN_CYCLES (`PSWC_CLK_HZ / 1000 * `PSWC_WINDOW_UNIT_MS)

`endif

// >>> core/pswc_pkg.sv
package pswc_pkg;

	typedef enum logic [2:0] {
		PSWC_RUN = 3'b001,
		PSWC_DECEL = 3'b010,
		PSWC_CP = 3'b100
	} pswc_state_t;

	typedef struct packed {
		logic leak;
		logic ready;
		logic cp;
		logic decel;
		logic run;
	} pswc_status_t;

	typedef struct packed {
		logic [15:0] setpoint;
		logic [15:0] feedback;
	} pswc_pid_t;

endpackage

// >>> core/pswc_tick.sv
`timescale 1ns/1ps

module pswc_tick #(
	parameter int unsigned PERIOD = 40000000
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic clr_i,
	output logic tick_o
);
	localparam int unsigned W = $clog2(PERIOD + 1);
	localparam logic [W-1:0] LAST = W'(PERIOD - 1);

	logic [W-1:0] cnt;

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt <= '0;
			tick_o <= 1'b0;
		end else if (clr_i) begin
			cnt <= '0;
			tick_o <= 1'b0;
		end else if (cnt == LAST) begin
			cnt <= '0;
			tick_o <= 1'b1;
		end else begin
			cnt <= cnt + W'(1);
			tick_o <= 1'b0;
		end
	end

endmodule // pswc_tick

// >>> bench/pswc_chk.sv
`timescale 1ns/1ps
`include "pswc_regs.svh"

module pswc_chk
	import pswc_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = 20,
	parameter int unsigned WIN_CYCLES = 4
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic [11:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire pswc_pid_t pid_i,
	input wire logic motor_stopped_i,
	input wire logic run_req_o,
	input wire logic stop_decel_req_o,
	input wire pswc_status_t status_o
);
	int unsigned run_cnt;
	logic armed;
	// Cycles spent running, saturating
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			run_cnt <= 0;
		end else if (!run_req_o) begin
			run_cnt <= 0;
		end else if (run_cnt < SEC_CYCLES) begin
			run_cnt <= run_cnt + 1;
		end
	end
	// Status register lags reset release by one edge
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			armed <= 1'b0;
		end else begin
			armed <= 1'b1;
		end
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	a_req_exclusive: assert property (!(run_req_o && stop_decel_req_o))
		else $error("run and stop requested together");
	a_status_run: assert property (armed |-> status_o.run == run_req_o)
		else $error("run status differs from run request");
	a_status_decel: assert property (armed |-> status_o.decel == stop_decel_req_o)
		else $error("decel status differs from stop request");
	a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data outside its cycle");
	a_level_readback: assert property (
		wr_i && addr_i == `PSWC_OFS_DEV_LEVEL && wdata_i <= `PSWC_MAX_DEV_LEVEL
		##1 rd_i && addr_i == `PSWC_OFS_DEV_LEVEL |=> rdata_o == $past(wdata_i, 2))
		else $error("deviation level readback wrong");
	a_detect_floor: assert property (
		wr_i && addr_i == `PSWC_OFS_DETECT_TIME && wdata_i == 16'h0000
		##1 rd_i && addr_i == `PSWC_OFS_DETECT_TIME |=> rdata_o == `PSWC_MIN_DETECT_TIME)
		else $error("detect time not held at one");
	a_cp_after_decel: assert property ($rose(status_o.cp) |-> $past(status_o.decel))
		else $error("constant pressure not reached from decel");
	a_decel_after_run: assert property ($rose(stop_decel_req_o) |-> $past(run_req_o))
		else $error("decel not entered from run");
	a_detect_dwell: assert property ($rose(stop_decel_req_o) |-> run_cnt >= SEC_CYCLES - 2)
		else $error("decel before one detect second");
	a_cp_motor_off: assert property (status_o.cp |-> !run_req_o && !stop_decel_req_o)
		else $error("motor requested in constant pressure");
	c_decel: cover property ($rose(stop_decel_req_o));
	c_cp: cover property ($rose(status_o.cp));
	c_wake: cover property ($fell(status_o.cp) ##0 run_req_o);
	c_leak: cover property (status_o.leak && status_o.cp);
endmodule // pswc_chk

bind pswc_ctrl pswc_chk #(.SEC_CYCLES(SEC_CYCLES), .WIN_CYCLES(WIN_CYCLES)) i_chk (
	.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pid_i(pid_i),
	.motor_stopped_i(motor_stopped_i), .run_req_o(run_req_o),
	.stop_decel_req_o(stop_decel_req_o), .status_o(status_o));

// >>> bench/pswc_ctrl_tb.sv
`timescale 1ns/1ps
`include "pswc_regs.svh"
`define CHK(a, b, m) chk((a) === (b), m)

module pswc_ctrl_tb
	import pswc_pkg::*;
;
	localparam int unsigned SEC = 20;
	localparam int unsigned WIN = 4;
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [11:0] addr_i = 12'h000;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [15:0] rdata_o;
	pswc_pid_t pid_i = '0;
	logic motor_stopped_i = 1'b0;
	logic run_req_o;
	logic stop_decel_req_o;
	pswc_status_t status_o;
	int n_fail = 0;
	int check_count = 0;
	int seed = 32'h8181_9af9;
	int exp_q [$];
	int n;
	int w;
	int e;
	logic [15:0] v;
	logic [11:0] ofs [5] = '{`PSWC_OFS_DEV_LEVEL, `PSWC_OFS_DETECT_TIME, `PSWC_OFS_LEAK_OFFSET,
		`PSWC_OFS_LEAK_THRESH, `PSWC_OFS_LEAK_WINDOW};
	int rstv [5] = '{0, 10, 0, 0, 5};
	int lo [5] = '{0, 1, 0, 0, 0};
	int hi [5] = '{100, 9999, 50, 100, 100};

	pswc_ctrl #(.SEC_CYCLES(SEC), .WIN_CYCLES(WIN)) i_dut (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pid_i(pid_i),
		.motor_stopped_i(motor_stopped_i), .run_req_o(run_req_o),
		.stop_decel_req_o(stop_decel_req_o), .status_o(status_o));

	initial begin
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end

	task automatic chk(input bit ok, input string m);
		check_count++;
		if (!ok) begin
			n_fail++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	task automatic wrap_up();
		if (n_fail == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic rd(input logic [11:0] a, output logic [15:0] d);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		@(posedge sys_clk_i);
	endtask

	// Write then read back with no gap
	task automatic wrrd(input logic [11:0] a, input logic [15:0] x, output logic [15:0] d);
		addr_i <= a;
		wdata_i <= x;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		@(posedge sys_clk_i);
	endtask

	// Wait until run request equals lvl, count cycles
	task automatic wait_run(input logic lvl, input int lim);
		n = 0;
		#1;
		while (run_req_o !== lvl && n < lim) begin
			@(posedge sys_clk_i);
			#1 n++;
		end
	endtask

	initial begin
		repeat (16) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		@(posedge sys_clk_i);
		for (int i = 0; i < 5; i++) begin
			rd(ofs[i], v);
			`CHK(v, rstv[i][15:0], "reset value");
		end
		rd(`PSWC_OFS_STATUS, v);
		`CHK(v, 16'h0001, "status after reset");
		rd(12'hc05, v);
		`CHK(v, 16'h0000, "unmapped read");
		for (int r = 0; r < 4; r++) begin
			for (int i = 0; i < 5; i++) begin
				w = (r == 0) ? 0 : (r == 1) ? hi[i] + 1 : $unsigned($random(seed)) % (hi[i] + 2);
				e = (w < lo[i]) ? lo[i] : (w > hi[i]) ? hi[i] : w;
				wrrd(ofs[i], w[15:0], v);
				`CHK(v, e[15:0], "clamped readback");
				if (r == 3) begin
					exp_q.push_back(e);
				end
			end
		end
		// Model of the last accepted settings, read back after all writes
		for (int i = 0; i < 5; i++) begin
			rd(ofs[i], v);
			`CHK(v, exp_q.pop_front(), "model readback");
		end
		wrrd(`PSWC_OFS_STATUS, 16'h001f, v);
		`CHK(v, 16'h0001, "status write ignored");
		wrrd(`PSWC_OFS_DEV_LEVEL, 16'h0005, v);
		wrrd(`PSWC_OFS_DETECT_TIME, 16'h0002, v);
		wrrd(`PSWC_OFS_LEAK_OFFSET, 16'h0000, v);
		wrrd(`PSWC_OFS_LEAK_THRESH, 16'h0000, v);
		wrrd(`PSWC_OFS_LEAK_WINDOW, 16'h0005, v);
		// Band 200: in band, broken before expiry, then in band again
		pid_i <= {16'h0fa0, 16'h0f3c};
		repeat (30) @(posedge sys_clk_i);
		pid_i <= {16'h0fa0, 16'h0e74};
		repeat (5) @(posedge sys_clk_i);
		pid_i <= {16'h0fa0, 16'h0f3c};
		wait_run(1'b0, 100);
		`CHK(n >= 2 * SEC - 2 && n <= 2 * SEC + 4, 1'b1, "detect time");
		`CHK(status_o, 5'b01010, "decel and ready");
		`CHK(stop_decel_req_o, 1'b1, "stop ramp request");
		@(posedge sys_clk_i);
		motor_stopped_i <= 1'b1;
		repeat (50) @(posedge sys_clk_i);
		#1 `CHK({status_o.cp, run_req_o, stop_decel_req_o, status_o.leak}, 4'b1000, "cp");
		@(posedge sys_clk_i);
		wrrd(`PSWC_OFS_LEAK_OFFSET, 16'h0019, v);
		// Drop 300 beyond band 200 but inside offset band 1000
		pid_i <= {16'h0fa0, 16'h0e74};
		repeat (10) @(posedge sys_clk_i);
		#1 `CHK(status_o.cp, 1'b1, "offset holds cp");
		@(posedge sys_clk_i);
		pid_i <= {16'h0fa0, 16'h0b54};
		wait_run(1'b1, 10);
		`CHK(n <= 4 && status_o.run === 1'b1, 1'b1, "pressure drop wake");
		@(posedge sys_clk_i);
		motor_stopped_i <= 1'b0;
		wrrd(`PSWC_OFS_LEAK_THRESH, 16'h0003, v);
		pid_i <= {16'h0fa0, 16'h0f3c};
		wait_run(1'b0, 100);
		@(posedge sys_clk_i);
		motor_stopped_i <= 1'b1;
		repeat (70) @(posedge sys_clk_i);
		#1 `CHK({status_o.cp, status_o.leak}, 2'b11, "leak flagged");
		@(posedge sys_clk_i);
		// Fall of 150 against change band 120 within one window
		pid_i <= {16'h0fa0, 16'h0ea6};
		wait_run(1'b1, 45);
		`CHK(run_req_o, 1'b1, "leak change wake");
		wrap_up();
	end

	initial begin
		#(25 * 4000);
		n_fail++;
		wrap_up();
	end
endmodule // pswc_ctrl_tb
